// File: src/sld_consts.svh
// Constants of the serial link deframer control block
// Notes on behaviour
// - Select set: /K/ then non-R/K requests sync
// - Select clear: disparity error count requests sync
// - Skip set: user data follows code group sync
// - Skip clear: alignment sequence precedes user data
// - Method clear: checksum sums individual fields
// - Method set: checksum sums whole configuration octets
// - Test mode: alignment sequence repeats for ever
// - Repeat test checks lanes against repeating pattern
// - Plain mode: simultaneous lane errors give one event
// - Queued mode: errors counted, signalled one by one
// - Auto clear zeroes only the causing counter
// - Multiframe length takes 1, 2, 4; resets 1
// - Count three error kinds; threshold resets all ones
// - Count equal threshold raises interrupt and/or sync
// - Counting and compare run in every lane
// - Masked threshold hit asserts sync; mask resets 7
// - Mask bit order reversed from counter order
// - Soft reset synchronous, restores deframer, stops reception
`ifndef SLD_CONSTS_SVH
`define SLD_CONSTS_SVH
// ==========================================================
// Register offsets
`define SLD_OFS_CTRL0 12'h475
`define SLD_OFS_SEQ 12'h476
`define SLD_OFS_TEST 12'h477
`define SLD_OFS_MFLEN 12'h478
`define SLD_OFS_THRES 12'h47C
`define SLD_OFS_MASK 12'h47D
// ==========================================================
// Field positions
`define SLD_B_SRESET 3
`define SLD_B_FORCESYNC 2
`define SLD_B_CGSSEL 2
`define SLD_B_NOILAS 1
`define SLD_B_CKMETH 0
`define SLD_B_ILSMODE 7
`define SLD_B_REPTEST 5
`define SLD_B_QUEUED 4
`define SLD_B_AUTOCLR 3
// ==========================================================
// Reset values
`define SLD_RST_CGSSEL 1'h1
`define SLD_RST_MFLEN 8'h01
`define SLD_RST_THRES 8'hFF
`define SLD_RST_MASK 3'h7
// ==========================================================
// Characters and timing
`define SLD_K_CHAR 8'hBC
`define SLD_R_CHAR 8'h1C
`define SLD_CLK_NS 10
`define SLD_ERR_PULSE_NS 20
`define SLD_ILAS_MF 4
`define SLD_MF_UNIT 4
`define SLD_DISP_LIMIT 4
`endif

// File: src/sld_pkg.sv
// Shared types of the serial link deframer control block
package sld_pkg;
	// ==========================================================
	// Carriers
	typedef struct packed {
		logic valid;
		logic is_k;
		logic [7:0] data;
		logic bad_disparity_error;
		logic not_in_table_error;
		logic unexpected_control_char_error;
	} sld_lane_in_t;
	typedef struct packed {
		logic wr;
		logic [11:0] addr;
		logic [7:0] wdata;
	} sld_reg_req_t;
	typedef enum logic [1:0] {
		SLD_WAIT_CGS,
		SLD_ILAS,
		SLD_DATA,
		SLD_TEST_ILAS
	} sld_link_st_t;
	typedef logic [13:0][7:0] sld_cfg_oct_t;
	typedef struct packed {
		sld_link_st_t st;
		logic user_data_en;
		logic checksum_err;
		logic [7:0] checksum_value;
	} sld_status_t;
endpackage

// File: src/sld_err_counter.sv
// Per-lane error counters with threshold compare and auto clear
`timescale 1ns/100ps
module sld_err_counter
	import sld_pkg::*;
#(
	parameter int CNT_W = 8
) (
	input wire logic clk_sys,
	input wire logic clr,
	input wire logic [2:0] err_in,
	input wire logic [CNT_W-1:0] threshold,
	input wire logic [2:0] sync_mask,
	input wire logic auto_clear,
	output logic [2:0] hit,
	output logic [2:0] sync_event
);
	typedef struct packed {
		logic [2:0][CNT_W-1:0] cnt;
		logic [2:0] hit_seen;
	} sld_cnt_state_t;
	sld_cnt_state_t q_ff;
	sld_cnt_state_t nxt_q;

	// ==========================================================
	// Compare; an event fires only on the first equal cycle
	for (genvar i = 0; i < 3; i++) begin : g_cmp
		assign hit[i] = (q_ff.cnt[i] == threshold);
		assign sync_event[i] = hit[i] & ~q_ff.hit_seen[i] & sync_mask[i];
	end

	// Counters saturate so a stuck lane cannot wrap past threshold
	always_comb begin
		nxt_q = q_ff;
		nxt_q.hit_seen = hit;
		for (int i = 0; i < 3; i++) begin
			if (auto_clear && sync_event[i]) begin
				nxt_q.cnt[i] = CNT_W'(err_in[i]); // New error not lost
			end else if (err_in[i] && !(&q_ff.cnt[i])) begin
				nxt_q.cnt[i] = q_ff.cnt[i] + 1'b1;
			end
		end
		if (clr) begin
			nxt_q = '0;
		end
	end

	always_ff @(posedge clk_sys) begin
		q_ff <= nxt_q;
	end

	a_auto_clear: assert property (@(posedge clk_sys) disable iff (clr)
		auto_clear && sync_event[0] && !err_in[0] |=> q_ff.cnt[0] == '0)
		else $error("causing counter not cleared");
	a_count_step: assert property (@(posedge clk_sys) disable iff (clr)
		err_in[1] && !auto_clear && q_ff.cnt[1] < threshold
		|=> q_ff.cnt[1] == $past(q_ff.cnt[1]) + 1'b1)
		else $error("error counter did not step");
endmodule

// File: src/sld_deframer_ctrl.sv
// Deframer link control, test modes and error reporting
`timescale 1ns/100ps
`include "sld_consts.svh"
module sld_deframer_ctrl
	import sld_pkg::*;
#(
	parameter int LANES = 8,
	parameter int DISP_LIMIT = `SLD_DISP_LIMIT
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire sld_reg_req_t reg_req,
	output logic [7:0] reg_rdata,
	input wire logic [LANES-1:0] cgs_done,
	input wire sld_lane_in_t [LANES-1:0] lane_in,
	input wire logic cfg_valid,
	input wire sld_cfg_oct_t cfg_oct,
	output logic sync_request_out_n,
	output logic threshold_irq,
	output sld_status_t status,
	output logic [LANES-1:0] pattern_err
);
	// ==========================================================
	// Timing
	localparam int PULSE_CYC =
		(`SLD_ERR_PULSE_NS + `SLD_CLK_NS - 1) / `SLD_CLK_NS;
	localparam logic [3:0] PULSE_LAST = 4'(PULSE_CYC - 1);
	localparam logic [7:0] DISP_LAST = 8'(DISP_LIMIT - 1);

	typedef struct packed {
		logic soft_rst;
		logic force_sync;
		logic post_sync_check_select;
		logic skip_alignment_sequence;
		logic ck_meth;
		logic alignment_test_mode;
		logic rep_test;
		logic queued;
		logic auto_clr;
		logic [7:0] mf_len;
		logic [7:0] thres;
		logic [2:0] mask;
		logic [7:0] rdata;
		sld_link_st_t st;
		logic [6:0] ilas_cnt;
		logic [7:0] disp_cnt;
		logic [7:0] q_cnt;
		logic [3:0] tmr;
		logic pulse_low;
		logic sync_n;
		logic [LANES-1:0] prev_k;
		logic [LANES-1:0] pat_full;
		logic [LANES-1:0] pat_err;
		logic [LANES-1:0][1:0] pat_idx;
		logic [LANES-1:0][3:0][7:0] pat;
		logic cks_err;
		logic [7:0] cks;
	} sld_ctrl_state_t;

	sld_ctrl_state_t q_ff;
	sld_ctrl_state_t nxt_q;
	logic dfr_rst;
	logic [2:0] mask_cnt_order;
	logic [LANES-1:0][2:0] lane_hit;
	logic [LANES-1:0][2:0] lane_ev;
	logic [7:0] ev_cnt;
	logic [8:0] q_sum;
	logic [6:0] ilas_last;
	logic resync;
	logic disp_seen;
	logic [7:0] fld_sum;
	logic [7:0] oct_sum;

	// ==========================================================
	// Per-lane error counters
	// soft reset clears deframer side
	assign dfr_rst = reset | q_ff.soft_rst;
	// mask bit 2 is bad disparity
	assign mask_cnt_order = {q_ff.mask[0], q_ff.mask[1], q_ff.mask[2]};

	for (genvar l = 0; l < LANES; l++) begin : g_lane
		sld_err_counter #(
			.CNT_W(8)
		) u_cnt (
			.clk_sys(clk_sys),
			.clr(dfr_rst),
			.err_in({lane_in[l].unexpected_control_char_error,
				lane_in[l].not_in_table_error,
				lane_in[l].bad_disparity_error}),
			.threshold(q_ff.thres),
			.sync_mask(mask_cnt_order),
			.auto_clear(q_ff.auto_clr),
			.hit(lane_hit[l]),
			.sync_event(lane_ev[l])
		);
	end

	assign threshold_irq = |lane_hit;

	// Checksum by fields; reserved octets count as fields
	// field-wise sum
	assign fld_sum = cfg_oct[0] + 8'(cfg_oct[1][7:4])
		+ 8'(cfg_oct[1][3:0]) + 8'(cfg_oct[2][6])
		+ 8'(cfg_oct[2][5]) + 8'(cfg_oct[2][4:0])
		+ 8'(cfg_oct[3][7]) + 8'(cfg_oct[3][4:0]) + cfg_oct[4]
		+ 8'(cfg_oct[5][4:0]) + cfg_oct[6] + 8'(cfg_oct[7][7:6])
		+ 8'(cfg_oct[7][4:0]) + 8'(cfg_oct[8][7:5])
		+ 8'(cfg_oct[8][4:0]) + 8'(cfg_oct[9][7:5])
		+ 8'(cfg_oct[9][4:0]) + 8'(cfg_oct[10][7])
		+ 8'(cfg_oct[10][4:0]) + cfg_oct[11] + cfg_oct[12];

	// Alignment phase length in octets, from multiframe count
	assign ilas_last = 7'(q_ff.mf_len * (`SLD_ILAS_MF * `SLD_MF_UNIT) - 1);

	// ==========================================================
	// Next-state logic
	always_comb begin
		nxt_q = q_ff;
		resync = 1'b0;
		disp_seen = 1'b0;
		ev_cnt = 8'h00;
		oct_sum = 8'h00;
		q_sum = 9'h000;
		// Register writes; settings are only legal under soft reset
		if (reg_req.wr) begin
			case (reg_req.addr)
				`SLD_OFS_CTRL0: begin
					nxt_q.soft_rst = reg_req.wdata[`SLD_B_SRESET];
					nxt_q.force_sync = reg_req.wdata[`SLD_B_FORCESYNC];
				end
				`SLD_OFS_SEQ: begin
					nxt_q.post_sync_check_select = reg_req.wdata[`SLD_B_CGSSEL];
					nxt_q.skip_alignment_sequence = reg_req.wdata[`SLD_B_NOILAS];
					nxt_q.ck_meth = reg_req.wdata[`SLD_B_CKMETH];
				end
				`SLD_OFS_TEST: begin
					nxt_q.alignment_test_mode = reg_req.wdata[`SLD_B_ILSMODE];
					nxt_q.rep_test = reg_req.wdata[`SLD_B_REPTEST];
					nxt_q.queued = reg_req.wdata[`SLD_B_QUEUED];
					nxt_q.auto_clr = reg_req.wdata[`SLD_B_AUTOCLR];
				end
				`SLD_OFS_MFLEN: begin
					if (reg_req.wdata == 8'h01 || reg_req.wdata == 8'h02
						|| reg_req.wdata == 8'h04) begin
						nxt_q.mf_len = reg_req.wdata;
					end
				end
				`SLD_OFS_THRES: nxt_q.thres = reg_req.wdata;
				`SLD_OFS_MASK: nxt_q.mask = reg_req.wdata[2:0];
				default: ;
			endcase
		end
		// Read data, one cycle after the address; holes read zero
		nxt_q.rdata = 8'h00;
		case (reg_req.addr)
			`SLD_OFS_CTRL0: begin
				nxt_q.rdata[`SLD_B_SRESET] = q_ff.soft_rst;
				nxt_q.rdata[`SLD_B_FORCESYNC] = q_ff.force_sync;
			end
			`SLD_OFS_SEQ: begin
				nxt_q.rdata[`SLD_B_CGSSEL] = q_ff.post_sync_check_select;
				nxt_q.rdata[`SLD_B_NOILAS] = q_ff.skip_alignment_sequence;
				nxt_q.rdata[`SLD_B_CKMETH] = q_ff.ck_meth;
			end
			`SLD_OFS_TEST: begin
				nxt_q.rdata[`SLD_B_ILSMODE] = q_ff.alignment_test_mode;
				nxt_q.rdata[`SLD_B_REPTEST] = q_ff.rep_test;
				nxt_q.rdata[`SLD_B_QUEUED] = q_ff.queued;
				nxt_q.rdata[`SLD_B_AUTOCLR] = q_ff.auto_clr;
			end
			`SLD_OFS_MFLEN: nxt_q.rdata = q_ff.mf_len;
			`SLD_OFS_THRES: nxt_q.rdata = q_ff.thres;
			`SLD_OFS_MASK: nxt_q.rdata = {5'h00, q_ff.mask};
			default: ;
		endcase

		// Post-sync character checks on every lane
		for (int l = 0; l < LANES; l++) begin
			if (lane_in[l].valid) begin
				disp_seen = disp_seen | lane_in[l].bad_disparity_error;
				// /K/ must be followed by /R/ or /K/
				if (q_ff.post_sync_check_select && q_ff.prev_k[l] && !(lane_in[l].is_k
					&& (lane_in[l].data == `SLD_K_CHAR
					|| lane_in[l].data == `SLD_R_CHAR))) begin
					resync = 1'b1;
				end
				nxt_q.prev_k[l] = lane_in[l].is_k
					&& lane_in[l].data == `SLD_K_CHAR;
			end
		end
		// disparity errors accumulate to a resync
		if (!q_ff.post_sync_check_select && disp_seen && q_ff.st != SLD_WAIT_CGS) begin
			if (q_ff.disp_cnt == DISP_LAST) begin
				resync = 1'b1;
				nxt_q.disp_cnt = 8'h00;
			end else begin
				nxt_q.disp_cnt = q_ff.disp_cnt + 8'h01;
			end
		end

		// Link sequencing after code group sync
		unique case (q_ff.st)
			SLD_WAIT_CGS: begin
				nxt_q.ilas_cnt = 7'h00;
				nxt_q.disp_cnt = 8'h00;
				if (&cgs_done) begin
					if (q_ff.alignment_test_mode) begin
						nxt_q.st = SLD_TEST_ILAS;
					end else if (q_ff.skip_alignment_sequence) begin
						nxt_q.st = SLD_DATA;
					end else begin
						nxt_q.st = SLD_ILAS;
					end
				end
			end
			SLD_ILAS, SLD_TEST_ILAS: begin
				if (lane_in[0].valid) begin
					if (q_ff.ilas_cnt == ilas_last) begin
						nxt_q.ilas_cnt = 7'h00;
						if (q_ff.st == SLD_ILAS) begin
							nxt_q.st = SLD_DATA;
						end
					end else begin
						nxt_q.ilas_cnt = q_ff.ilas_cnt + 7'h01;
					end
				end
			end
			SLD_DATA: ;
		endcase
		// Lost lane sync or a check failure restarts the link
		if (q_ff.st != SLD_WAIT_CGS && (resync || !(&cgs_done))) begin
			nxt_q.st = SLD_WAIT_CGS;
		end

		// Repeat pattern: first four octets learnt, then compared
		// relies on test mode being clear
		if (q_ff.rep_test && !q_ff.alignment_test_mode && q_ff.st == SLD_DATA) begin
			for (int l = 0; l < LANES; l++) begin
				if (lane_in[l].valid) begin
					if (!q_ff.pat_full[l]) begin
						nxt_q.pat[l][q_ff.pat_idx[l]] = lane_in[l].data;
						nxt_q.pat_full[l] = &q_ff.pat_idx[l];
					end else if (q_ff.pat[l][q_ff.pat_idx[l]]
						!= lane_in[l].data) begin
						nxt_q.pat_err[l] = 1'b1;
					end
					nxt_q.pat_idx[l] = q_ff.pat_idx[l] + 2'h1;
				end
			end
		end

		// Configuration checksum, chosen by method
		for (int i = 0; i < 13; i++) begin
			oct_sum = oct_sum + cfg_oct[i];
		end
		if (cfg_valid) begin
			nxt_q.cks = q_ff.ck_meth ? oct_sum : fld_sum;
			nxt_q.cks_err = (nxt_q.cks != cfg_oct[13]);
		end

		// Error events: one per cycle, or every one when queued
		for (int l = 0; l < LANES; l++) begin
			for (int i = 0; i < 3; i++) begin
				ev_cnt = ev_cnt + 8'(lane_ev[l][i]);
			end
		end
		if (q_ff.queued) begin
			q_sum = {1'b0, q_ff.q_cnt} + {1'b0, ev_cnt};
			if (q_sum[8]) begin
				q_sum = 9'h0FF;
			end
		end else begin
			q_sum = {8'h00, (|q_ff.q_cnt) | (|lane_ev)};
		end
		// Each pending event becomes a low pulse then a high gap
		if (q_ff.tmr != 4'h0) begin
			nxt_q.tmr = q_ff.tmr - 4'h1;
		end else if (q_ff.pulse_low) begin
			nxt_q.pulse_low = 1'b0;
			nxt_q.tmr = PULSE_LAST;
		end else if (q_sum != 9'h000) begin
			nxt_q.pulse_low = 1'b1;
			nxt_q.tmr = PULSE_LAST;
			q_sum = q_sum - 9'h001;
		end
		nxt_q.q_cnt = q_sum[7:0];

		// soft reset returns deframer to power-on state
		if (q_ff.soft_rst) begin
			nxt_q.st = SLD_WAIT_CGS;
			nxt_q.ilas_cnt = 7'h00;
			nxt_q.disp_cnt = 8'h00;
			nxt_q.q_cnt = 8'h00;
			nxt_q.tmr = 4'h0;
			nxt_q.pulse_low = 1'b0;
			nxt_q.prev_k = '0;
			nxt_q.pat_full = '0;
			nxt_q.pat_err = '0;
			nxt_q.pat_idx = '0;
			nxt_q.pat = '0;
			nxt_q.cks_err = 1'b0;
			nxt_q.cks = 8'h00;
		end
		// sync low while unsynced, forced or reporting
		nxt_q.sync_n = !(nxt_q.st == SLD_WAIT_CGS || nxt_q.force_sync
			|| nxt_q.pulse_low);
	end

	// ==========================================================
	// State register; settings survive soft reset
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			q_ff <= '0;
			q_ff.post_sync_check_select <= `SLD_RST_CGSSEL;
			q_ff.mf_len <= `SLD_RST_MFLEN;
			q_ff.thres <= `SLD_RST_THRES;
			q_ff.mask <= `SLD_RST_MASK;
		end else begin
			q_ff <= nxt_q;
		end
	end

	// Outputs
	assign reg_rdata = q_ff.rdata;
	assign sync_request_out_n = q_ff.sync_n;
	assign pattern_err = q_ff.pat_err;
	assign status.st = q_ff.st;
	assign status.user_data_en = (q_ff.st == SLD_DATA);
	assign status.checksum_err = q_ff.cks_err;
	assign status.checksum_value = q_ff.cks;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (dfr_rst);

	sequence s_err_pulse;
		!sync_request_out_n [*2] ##1 sync_request_out_n [*2];
	endsequence

	a_kchar_resync: assert property (q_ff.post_sync_check_select && q_ff.st == SLD_DATA
		&& lane_in[0].valid && q_ff.prev_k[0] && !lane_in[0].is_k
		|=> q_ff.st == SLD_WAIT_CGS)
		else $error("bad /K/ follower did not resync");
	a_disp_only: assert property (!q_ff.post_sync_check_select && q_ff.st == SLD_DATA
		&& !disp_seen && &cgs_done |=> q_ff.st == SLD_DATA)
		else $error("resync without disparity errors");
	a_skip_ilas: assert property (q_ff.st == SLD_WAIT_CGS && &cgs_done
		&& q_ff.skip_alignment_sequence && !q_ff.alignment_test_mode
		|=> q_ff.st == SLD_DATA)
		else $error("skip option did not go to data");
	a_ilas_first: assert property (q_ff.st == SLD_WAIT_CGS && &cgs_done
		&& !q_ff.skip_alignment_sequence && !q_ff.alignment_test_mode
		|=> q_ff.st == SLD_ILAS)
		else $error("alignment sequence not expected");
	a_test_ilas: assert property (q_ff.alignment_test_mode
		|-> q_ff.st != SLD_DATA)
		else $error("test mode reached user data");
	a_cks_octets: assert property (cfg_valid && q_ff.ck_meth
		|=> status.checksum_value == $past(oct_sum))
		else $error("octet checksum wrong");
	a_cks_fields: assert property (cfg_valid && !q_ff.ck_meth
		|=> status.checksum_value == $past(fld_sum))
		else $error("field checksum wrong");
	a_pattern_chk: assert property (q_ff.rep_test && !q_ff.alignment_test_mode
		&& q_ff.st == SLD_DATA && lane_in[0].valid && q_ff.pat_full[0]
		&& lane_in[0].data != q_ff.pat[0][q_ff.pat_idx[0]]
		|=> pattern_err[0])
		else $error("pattern mismatch not flagged");
	a_single_event: assert property (!q_ff.queued
		|-> q_ff.q_cnt <= 8'h01)
		else $error("plain mode queued several events");
	a_queue_pulses: assert property (q_ff.queued && q_ff.st == SLD_DATA
		&& !q_ff.force_sync && q_ff.q_cnt == 8'h00 && q_ff.tmr == 4'h0
		&& !q_ff.pulse_low && ev_cnt == 8'h02
		|=> s_err_pulse ##1 !sync_request_out_n)
		else $error("queued errors not signalled in turn");
	a_mflen_valid: assert property (q_ff.mf_len == 8'h01
		|| q_ff.mf_len == 8'h02 || q_ff.mf_len == 8'h04)
		else $error("illegal multiframe length held");
	// Last error before threshold must raise the interrupt next cycle
	a_irq_thres: assert property (q_ff.thres != 8'h00
		&& lane_in[0].unexpected_control_char_error
		&& g_lane[0].u_cnt.q_ff.cnt[2] == q_ff.thres - 8'h01
		|=> threshold_irq)
		else $error("threshold hit without interrupt");
	a_sync_mask: assert property (!q_ff.queued && |lane_ev
		|-> ##[1:8] !sync_request_out_n)
		else $error("masked hit did not assert sync");
	a_mask_order: assert property (q_ff.thres != 8'h00 && q_ff.mask[2]
		&& lane_in[LANES-1].bad_disparity_error
		&& g_lane[LANES-1].u_cnt.q_ff.cnt[0] == q_ff.thres - 8'h01
		|=> lane_ev[LANES-1][0])
		else $error("mask bit 2 did not enable bad disparity");
	a_soft_reset: assert property (@(posedge clk_sys) disable iff (reset)
		q_ff.soft_rst |=> status.st == SLD_WAIT_CGS
		&& !sync_request_out_n && pattern_err == '0)
		else $error("soft reset did not restore deframer");
endmodule

// File: verification/sld_framer_model.sv
// Behavioural transmitter framer model driving the deframer lanes
`timescale 1ns/100ps
`include "sld_consts.svh"
module sld_framer_model
	import sld_pkg::*;
#(
	parameter int LANES = 2
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic link_up,
	input wire logic [1:0] mode,
	input wire logic err_go,
	input wire logic [2:0] err_kind,
	input wire logic [LANES-1:0] err_lane,
	input wire logic corrupt,
	input wire logic [31:0] pat,
	output logic [LANES-1:0] cgs_done,
	output sld_lane_in_t [LANES-1:0] lane_in
);
	// ==========================================================
	// State
	typedef struct packed {
		logic cgs;
		logic [1:0] prev_mode;
		logic [1:0] idx;
	} sld_fm_state_t;
	sld_fm_state_t st_ff;
	sld_fm_state_t nxt_st;
	logic r_first;
	logic [7:0] octet;

	// Mode 0/2 send /K/, mode 1 sends the pattern; /R/ only after mode 0
	always_comb begin
		r_first = (mode == 2'h1) && (st_ff.prev_mode == 2'h0);
		octet = pat[8*st_ff.idx +: 8];
		nxt_st = st_ff;
		nxt_st.cgs = link_up;
		nxt_st.prev_mode = mode;
		if (mode == 2'h1 && !r_first) begin
			nxt_st.idx = st_ff.idx + 2'h1;
		end
		for (int l = 0; l < LANES; l++) begin
			lane_in[l].valid = ~reset;
			lane_in[l].is_k = (mode != 2'h1) || r_first;
			if (r_first) begin
				lane_in[l].data = `SLD_R_CHAR;
			end else if (mode != 2'h1) begin
				lane_in[l].data = `SLD_K_CHAR;
			end else begin
				lane_in[l].data = octet ^ {8{corrupt & err_lane[l]}};
			end
			lane_in[l].bad_disparity_error = err_go & err_lane[l] & err_kind[2];
			lane_in[l].not_in_table_error = err_go & err_lane[l] & err_kind[1];
			lane_in[l].unexpected_control_char_error =
				err_go & err_lane[l] & err_kind[0];
		end
		cgs_done = {LANES{st_ff.cgs}};
	end

	// Register the state copy
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end
endmodule

// File: verification/test_sld_deframer_ctrl.sv
// Self-checking bench for the deframer link control block
`timescale 1ns/100ps
`include "sld_consts.svh"
module test_sld_deframer_ctrl
	import sld_pkg::*;
;
	// ==========================================================
	// Signals
	localparam int LN = 2;
	typedef struct {
		logic [2:0] kind;
		logic [7:0] exp;
	} sld_note_t;
	logic clk_sys, reset, cfg_valid, sync_request_out_n, threshold_irq;
	sld_reg_req_t reg_req;
	logic [7:0] reg_rdata;
	logic [LN-1:0] cgs_done, pattern_err, err_lane;
	sld_lane_in_t [LN-1:0] lane_in;
	sld_cfg_oct_t cfg_oct;
	sld_status_t status;
	logic link_up, err_go, corrupt, sync_prev;
	logic [1:0] mode;
	logic [2:0] err_kind, km;
	logic [31:0] pat, seed;
	logic [7:0] kv [4];
	logic [7:0] prev_k;
	int falls, fall_base, n_tests, bad_count;
	sld_note_t notes[$];
	sld_note_t nt;
	string names [8];

	sld_deframer_ctrl #(.LANES(LN), .DISP_LIMIT(2)) dut (
		.clk_sys(clk_sys), .reset(reset), .reg_req(reg_req),
		.reg_rdata(reg_rdata), .cgs_done(cgs_done), .lane_in(lane_in),
		.cfg_valid(cfg_valid), .cfg_oct(cfg_oct),
		.sync_request_out_n(sync_request_out_n),
		.threshold_irq(threshold_irq), .status(status),
		.pattern_err(pattern_err));
	sld_framer_model #(.LANES(LN)) framer (
		.clk_sys(clk_sys), .reset(reset), .link_up(link_up), .mode(mode),
		.err_go(err_go), .err_kind(err_kind), .err_lane(err_lane),
		.corrupt(corrupt), .pat(pat), .cgs_done(cgs_done),
		.lane_in(lane_in));

	// ==========================================================
	// Clock, watchdog and checking
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// Run needs about 1000 cycles; twenty times that is a hang
	initial begin
		#(20000 * 10);
		bad_count++;
		results();
	end
	// Count sync request assertions seen on the pin
	always @(posedge clk_sys) begin
		sync_prev <= sync_request_out_n;
		if (sync_prev === 1'b1 && sync_request_out_n === 1'b0) begin
			falls <= falls + 1;
		end
	end
	// Every pending note, oldest first, against the output it names, mid-cycle when settled
	always @(negedge clk_sys) begin
		while (notes.size() > 0) begin
			nt = notes.pop_front();
			chk(names[nt.kind], nt.exp, seen(nt.kind));
		end
	end

	function automatic logic [7:0] seen(input logic [2:0] k);
		case (k)
			3'h0: seen = reg_rdata;
			3'h1: seen = 8'(status.st);
			3'h2: seen = 8'(sync_request_out_n);
			3'h3: seen = 8'(threshold_irq);
			3'h4: seen = status.checksum_value;
			3'h5: seen = 8'(status.checksum_err);
			3'h6: seen = 8'(pattern_err);
			default: seen = 8'(falls - fall_base);
		endcase
	endfunction
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
		n_tests++;
		if (s !== e) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic results();
		$display("Checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// ==========================================================
	// Drivers
	task automatic note(input logic [2:0] k, input logic [7:0] e);
		notes.push_back('{kind: k, exp: e});
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_req <= '{wr: 1'b1, addr: a, wdata: d};
		@(posedge clk_sys);
		reg_req.wr <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		reg_req <= '{wr: 1'b0, addr: a, wdata: 8'h00};
		wait_n(2);
		note(3'h0, e);
	endtask
	task automatic setup(input logic [7:0] sq, input logic [7:0] ts,
		input logic [7:0] th, input logic [7:0] mk);
		wr(`SLD_OFS_CTRL0, 8'h08);
		wr(`SLD_OFS_SEQ, sq);
		wr(`SLD_OFS_TEST, ts);
		wr(`SLD_OFS_THRES, th);
		wr(`SLD_OFS_MASK, mk);
		wr(`SLD_OFS_CTRL0, 8'h00);
		wait_n(30);
		fall_base = falls;
	endtask
	task automatic inj(input logic [1:0] ln, input logic [2:0] k, input int n,
		input int len);
		repeat (n) begin
			@(posedge clk_sys);
			err_lane <= ln;
			err_kind <= k;
			err_go <= 1'b1;
			wait_n(len);
			err_go <= 1'b0;
		end
	endtask

	// ==========================================================
	// Scenarios; two lanes keep skip_alignment_sequence at 0
	initial begin
		names = '{"rdata", "state", "sync_n", "irq", "ck_value", "ck_err",
			"pat_err", "falls"};
		reset = 1'b1; reg_req = '0; cfg_valid = 1'b0; cfg_oct = '0;
		link_up = 1'b0; mode = 2'h0; err_go = 1'b0; err_kind = 3'h0;
		err_lane = '0; corrupt = 1'b0; seed = 32'h00005540;
		pat = 32'h00000000; falls = 0; fall_base = 0; sync_prev = 1'b0;
		n_tests = 0; bad_count = 0; kv = '{8'h03, 8'h02, 8'h04, 8'h01};
		wait_n(8);
		reset <= 1'b0;
		rd(`SLD_OFS_SEQ, 8'h04);
		rd(`SLD_OFS_TEST, 8'h00);
		rd(`SLD_OFS_MFLEN, 8'h01);
		rd(`SLD_OFS_THRES, 8'hFF);
		rd(`SLD_OFS_MASK, 8'h07);
		rd(12'h400, 8'h00);
		prev_k = 8'h01;
		for (int i = 0; i < 4; i++) begin
			wr(`SLD_OFS_CTRL0, 8'h08);
			wr(`SLD_OFS_MFLEN, kv[i]);
			wr(`SLD_OFS_CTRL0, 8'h00);
			if (kv[i] != 8'h03) prev_k = kv[i];
			rd(`SLD_OFS_MFLEN, prev_k);
		end
		// Link up: alignment sequence, then user data
		setup(8'h04, 8'h00, 8'hFF, 8'h07);
		@(posedge clk_sys);
		link_up <= 1'b1;
		mode <= 2'h1;
		wait_n(6);
		note(3'h1, 8'(SLD_ILAS));
		note(3'h2, 8'h01);
		wait_n(20);
		note(3'h1, 8'(SLD_DATA));
		// /K/ followed by plain data in user data
		@(posedge clk_sys);
		mode <= 2'h2;
		@(posedge clk_sys);
		mode <= 2'h1;
		wait_n(8);
		note(3'h7, 8'h01);
		note(3'h1, 8'(SLD_ILAS));
		// Disparity errors with the post-sync check cleared
		setup(8'h00, 8'h00, 8'hFF, 8'h07);
		inj(2'h1, 3'h4, 1, 1);
		wait_n(6);
		note(3'h7, 8'h00);
		inj(2'h1, 3'h4, 1, 2);
		wait_n(6);
		note(3'h7, 8'h01);
		// Each error kind against its mask bit, on lane 1
		for (int k = 0; k < 3; k++) begin
			km = 3'h1 << k;
			setup(8'h04, 8'h00, 8'h02, 8'(~km));
			inj(2'h2, km, 2, 1);
			wait_n(6);
			note(3'h3, 8'h01);
			note(3'h7, 8'h00);
			setup(8'h04, 8'h00, 8'h02, 8'(km));
			inj(2'h2, km, 1, 1);
			wait_n(6);
			note(3'h3, 8'h00);
			inj(2'h2, km, 1, 1);
			wait_n(6);
			note(3'h7, 8'h01);
			note(3'h3, 8'h01);
		end
		// Auto clear: only the counter behind the request restarts
		setup(8'h04, 8'h08, 8'h02, 8'h01);
		inj(2'h2, 3'h2, 2, 1);
		inj(2'h1, 3'h1, 2, 1);
		wait_n(8);
		note(3'h7, 8'h01);
		note(3'h3, 8'h01);
		inj(2'h1, 3'h1, 2, 1);
		wait_n(8);
		note(3'h7, 8'h02);
		// Errors on both lanes at once, plain then queued
		setup(8'h04, 8'h00, 8'h01, 8'h07);
		inj(2'h3, 3'h2, 1, 1);
		wait_n(12);
		note(3'h7, 8'h01);
		setup(8'h04, 8'h10, 8'h01, 8'h07);
		inj(2'h3, 3'h2, 1, 1);
		wait_n(14);
		note(3'h7, 8'h02);
		// Checksum: octet 3 packs two fields, received sum is 0x02
		for (int m = 0; m < 2; m++) begin
			setup(8'h04 | 8'(m), 8'h00, 8'hFF, 8'h07);
			@(posedge clk_sys);
			cfg_oct[3] <= 8'h81;
			cfg_oct[13] <= 8'h02;
			cfg_valid <= 1'b1;
			@(posedge clk_sys);
			cfg_valid <= 1'b0;
			wait_n(2);
			note(3'h4, (m == 1) ? 8'h81 : 8'h02);
			note(3'h5, 8'(m));
		end
		// repeat test with test mode cleared
		pat <= xs();
		setup(8'h04, 8'h20, 8'hFF, 8'h07);
		note(3'h6, 8'h00);
		@(posedge clk_sys);
		err_lane <= 2'h2;
		corrupt <= 1'b1;
		@(posedge clk_sys);
		corrupt <= 1'b0;
		wait_n(3);
		note(3'h6, 8'h02);
		// Soft reset stops the link but keeps the settings
		wr(`SLD_OFS_CTRL0, 8'h08);
		wait_n(3);
		note(3'h1, 8'(SLD_WAIT_CGS));
		note(3'h2, 8'h00);
		note(3'h6, 8'h00);
		rd(`SLD_OFS_TEST, 8'h20);
		setup(8'h04, 8'h80, 8'hFF, 8'h07);
		wait_n(30);
		note(3'h1, 8'(SLD_TEST_ILAS));
		wait_n(2);
		results();
	end
endmodule
